/* core/fam_consts.vh */
// Constants for the fan alarm manager: register numbers, alarm codes, timing
`ifndef FAM_CONSTS_VH
`define FAM_CONSTS_VH
// Register numbers
`define FAM_IR_FW_VER 16'h0000
`define FAM_IR_DRV_MODEL 16'h0001
`define FAM_IR_GROUP 16'h000A
`define FAM_IR_DETAIL 16'h0011
`define FAM_HR_GEN_RESET 16'h0000
`define FAM_HR_FIX_A 16'h0015
`define FAM_HR_FIX_B 16'h001E
`define FAM_HR_FIX_C 16'h0027
`define FAM_HR_FAN_MODEL 16'h002C
`define FAM_HR_OUT_FUNC 16'h002E
`define FAM_HR_FIX_D 16'h0032
`define FAM_HR_COMM_TMO 16'h0038
`define FAM_HR_INPUT_TYPE 16'h0040
// Register values
`define FAM_OUT_FUNC_ALARM 16'h0001
`define FAM_GEN_RESET_CMD 16'h0001
`define FAM_ZERO16 16'h0000
`define FAM_FAN_MODEL_RST 16'h0001
`define FAM_INPUT_TYPE_RST 16'h0000
// Alarm groups and details
`define FAM_GRP_NONE 8'h00
`define FAM_GRP_MEM 8'h01
`define FAM_GRP_SHORT 8'h02
`define FAM_GRP_SYNC 8'h03
`define FAM_GRP_MISC 8'h04
`define FAM_DET_NONE 8'h00
`define FAM_DET_VIN 8'h01
`define FAM_DET_OVP 8'h20
`define FAM_DET_UVP 8'h21
`define FAM_DET_RELAY 8'h22
`define FAM_DET_PH_U 8'h31
`define FAM_DET_PH_V 8'h32
`define FAM_DET_PH_W 8'h33
`define FAM_DET_ISTART 8'h34
`define FAM_DET_TEMP 8'h71
`define FAM_DET_COMM 8'hFF
// Power classes; only the top class blocks on repeated failed restarts
`define FAM_PWR_TOP 2'h3
`define FAM_SYNC_LAST 3'h4
// Edges a pin needs to cross the two-flop synchroniser
`define FAM_SYNC_DEPTH 2'h2
// Operating modes derived from the input type
`define FAM_MODE_OTHER 2'h0
`define FAM_MODE_ANALOG 2'h1
`define FAM_MODE_FIXED 2'h2
`define FAM_MODE_TEMP 2'h3
// Timing
`define FAM_CLK_HZ 32'h02625A00
`define FAM_RESTART_S 16'h0005
`endif

/* core/fam_alarm_manager.v */
// Fan drive alarm manager: fault classing, alarm codes, alarm output, resets
`default_nettype none
`include "fam_consts.vh"

// Functional notes
// - Blocking alarm stops motor at once; stays stopped until reset or power loss.
// - Auto-restarting alarm raises indications, then restarts motor after several seconds.
// - Fault shown as group plus detail code; both zero means no fault.
// - Memory error is group 1, short circuit group 2; both blocking.
// - Loss of synchronism is group 3; auto-restarting on lower power classes.
// - Top power class blocks after four failed restarts following synchronism loss.
// - Input voltage out of range flagged only with motor stopped: 4/1, auto.
// - Bus overvoltage 4/32, undervoltage 4/33; both auto-restarting.
// - Input relay not closed is 4/34, auto-restarting.
// - Missing phase U, V, W gives 4/49, 4/50, 4/51; all blocking.
// - High start current 4/52 and overtemperature 4/113 auto; lost link 4/255 blocking.
// - Output function register set to 1 turns digital output into alarm output.
// - Alarm output low in normal running, high while any alarm is active.
// - Analog input types clear alarms when the reference falls to zero.
// - Fixed input types clear alarms when the four set registers are zero.
// - Temporary bus input types clear alarms by writing 1 to register 0.
// - Writing 1 to register 0 resets alarms in every operating mode.
// - Fan model code is presented in holding register 44.
// - Firmware version and driver model are read-only input registers 0 and 1.
// - Nonzero link timeout stops fan with alarm on expiry; zero disables it.
// - Thermal alarm clears itself once module temperature is back below threshold.
module fam_alarm_manager #(
   parameter [15:0] FW_VERSION = 16'h0100,   // Arbitrary value
   parameter [15:0] DRV_MODEL = 16'h00A5,    // Arbitrary value
   parameter [31:0] TICKS_PER_S = `FAM_CLK_HZ,
   parameter [15:0] RESTART_S = `FAM_RESTART_S
) (
   input wire i_clk_sys,
   input wire i_rst_b,
   input wire i_reg_wr,
   input wire i_reg_rd,
   input wire i_reg_is_input,
   input wire [15:0] i_reg_addr,
   input wire [15:0] i_reg_wdata,
   input wire i_flt_mem,
   input wire i_flt_short,
   input wire i_flt_sync,
   input wire i_flt_vin,
   input wire i_flt_ovp,
   input wire i_flt_uvp,
   input wire i_flt_relay,
   input wire [2:0] i_flt_phase,
   input wire i_flt_istart,
   input wire i_temp_hot,
   input wire i_motor_running,
   input wire i_ref_zero,
   input wire [1:0] i_power_class,
   output reg [15:0] o_reg_rdata,
   output reg o_reg_rack,
   output reg o_motor_stop,
   output reg o_restart,
   output reg o_alarm_active,
   output reg o_dout
);

   // ----------------------------------------------------------------
   // Local definitions
   // ----------------------------------------------------------------
   localparam [1:0] ST_RUN = 2'b00;
   localparam [1:0] ST_AUTO = 2'b01;
   localparam [1:0] ST_BLOCK = 2'b10;
   localparam NPIN = 16;

   // Picks the highest-priority active fault: {blocking, group, detail}
   function [16:0] fam_pick;
      input [12:0] f;
      begin
         if (f[0]) fam_pick = {1'b1, `FAM_GRP_MEM, `FAM_DET_NONE};
         else if (f[1]) fam_pick = {1'b1, `FAM_GRP_SHORT, `FAM_DET_NONE};
         else if (f[2]) fam_pick = {1'b1, `FAM_GRP_MISC, `FAM_DET_PH_U};
         else if (f[3]) fam_pick = {1'b1, `FAM_GRP_MISC, `FAM_DET_PH_V};
         else if (f[4]) fam_pick = {1'b1, `FAM_GRP_MISC, `FAM_DET_PH_W};
         else if (f[5]) fam_pick = {1'b1, `FAM_GRP_MISC, `FAM_DET_COMM};
         else if (f[6]) fam_pick = {1'b0, `FAM_GRP_SYNC, `FAM_DET_NONE};
         else if (f[7]) fam_pick = {1'b0, `FAM_GRP_MISC, `FAM_DET_VIN};
         else if (f[8]) fam_pick = {1'b0, `FAM_GRP_MISC, `FAM_DET_OVP};
         else if (f[9]) fam_pick = {1'b0, `FAM_GRP_MISC, `FAM_DET_UVP};
         else if (f[10]) fam_pick = {1'b0, `FAM_GRP_MISC, `FAM_DET_RELAY};
         else if (f[11]) fam_pick = {1'b0, `FAM_GRP_MISC, `FAM_DET_ISTART};
         else fam_pick = {1'b0, `FAM_GRP_MISC, `FAM_DET_TEMP};
      end
   endfunction

   // Maps a holding register number onto the fixed-mode set registers
   function [2:0] fam_fix_idx;
      input [15:0] a;
      begin
         if (a == `FAM_HR_FIX_A) fam_fix_idx = 3'b100;
         else if (a == `FAM_HR_FIX_B) fam_fix_idx = 3'b101;
         else if (a == `FAM_HR_FIX_C) fam_fix_idx = 3'b110;
         else if (a == `FAM_HR_FIX_D) fam_fix_idx = 3'b111;
         else fam_fix_idx = 3'b000;
      end
   endfunction

   // Operating mode from the input type register
   function [1:0] fam_mode;
      input [15:0] t;
      begin
         case (t)
            16'h0001, 16'h0004, 16'h0007, 16'h000A: fam_mode = `FAM_MODE_ANALOG;
            16'h0002, 16'h0006, 16'h0009, 16'h000C: fam_mode = `FAM_MODE_FIXED;
            16'h0000, 16'h0005, 16'h0008, 16'h000B: fam_mode = `FAM_MODE_TEMP;
            default: fam_mode = `FAM_MODE_OTHER;
         endcase
      end
   endfunction

   // ----------------------------------------------------------------
   // Pin synchronisers
   // ----------------------------------------------------------------
   wire [NPIN-1:0] pin_raw;
   reg [NPIN-1:0] pin_meta;
   reg [NPIN-1:0] pin_s;
   assign pin_raw = {i_power_class, i_ref_zero, i_motor_running, i_temp_hot, i_flt_istart,
                     i_flt_relay, i_flt_uvp, i_flt_ovp, i_flt_vin, i_flt_sync, i_flt_phase,
                     i_flt_short, i_flt_mem};

   // Two stages per pin; only the second stage feeds logic
   genvar gi;
   generate
      for (gi = 0; gi < NPIN; gi = gi + 1) begin : g_sync
         always @(posedge i_clk_sys or negedge i_rst_b) begin
            if (!i_rst_b) begin
               pin_meta[gi] <= 1'b0;
               pin_s[gi] <= 1'b0;
            end else begin
               pin_meta[gi] <= pin_raw[gi];
               pin_s[gi] <= pin_meta[gi];
            end
         end
      end
   endgenerate

   wire motor_running_s = pin_s[12];
   wire ref_zero_s = pin_s[13];
   wire temp_hot_s = pin_s[11];

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   reg [15:0] fan_model;
   reg [15:0] out_func;
   reg [15:0] comm_tmo;
   reg [15:0] input_type;
   reg [15:0] fix_reg [0:3];
   reg [7:0] grp_code;
   reg [7:0] det_code;
   reg [1:0] state;
   reg [1:0] pwr_class;
   reg class_taken;
   reg gen_reset;
   reg fix_clear;
   wire [2:0] wr_fix = fam_fix_idx(i_reg_addr);
   wire hr_wr = i_reg_wr & ~i_reg_is_input;
   wire [1:0] mode = fam_mode(input_type);
   integer k;

   // Holding register writes; fan model and set registers are plain storage
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         fan_model <= `FAM_FAN_MODEL_RST;
         out_func <= `FAM_ZERO16;
         comm_tmo <= `FAM_ZERO16;
         input_type <= `FAM_INPUT_TYPE_RST;
         for (k = 0; k < 4; k = k + 1) begin
            fix_reg[k] <= `FAM_ZERO16;
         end
      end else if (hr_wr) begin
         if (i_reg_addr == `FAM_HR_FAN_MODEL) begin
            fan_model <= i_reg_wdata;
         end else if (i_reg_addr == `FAM_HR_OUT_FUNC) begin
            out_func <= i_reg_wdata;
         end else if (i_reg_addr == `FAM_HR_COMM_TMO) begin
            comm_tmo <= i_reg_wdata;
         end else if (i_reg_addr == `FAM_HR_INPUT_TYPE) begin
            input_type <= i_reg_wdata;
         end else if (wr_fix[2]) begin
            fix_reg[wr_fix[1:0]] <= i_reg_wdata;
         end
      end
   end

   // Reset commands are one-cycle pulses; register 0 reads back as zero
   reg others_zero;
   integer j;
   always @* begin
      others_zero = 1'b1;
      for (j = 0; j < 4; j = j + 1) begin
         if ((j != wr_fix[1:0]) && (fix_reg[j] != `FAM_ZERO16)) others_zero = 1'b0;
      end
   end

   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         gen_reset <= 1'b0;
         fix_clear <= 1'b0;
      end else begin
         gen_reset <= hr_wr && (i_reg_addr == `FAM_HR_GEN_RESET) &&
                      (i_reg_wdata == `FAM_GEN_RESET_CMD);
         fix_clear <= hr_wr && wr_fix[2] && (i_reg_wdata == `FAM_ZERO16) &&
                      others_zero && (mode == `FAM_MODE_FIXED);
      end
   end

   // Read port: answer one cycle after the request, unmapped reads give zero
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_reg_rdata <= `FAM_ZERO16;
         o_reg_rack <= 1'b0;
      end else begin
         o_reg_rack <= i_reg_rd;
         if (i_reg_rd) begin
            if (i_reg_is_input) begin
               if (i_reg_addr == `FAM_IR_FW_VER) o_reg_rdata <= FW_VERSION;
               else if (i_reg_addr == `FAM_IR_DRV_MODEL) o_reg_rdata <= DRV_MODEL;
               else if (i_reg_addr == `FAM_IR_GROUP) o_reg_rdata <= {8'h00, grp_code};
               else if (i_reg_addr == `FAM_IR_DETAIL) o_reg_rdata <= {8'h00, det_code};
               else o_reg_rdata <= `FAM_ZERO16;
            end else begin
               if (i_reg_addr == `FAM_HR_FAN_MODEL) o_reg_rdata <= fan_model;
               else if (i_reg_addr == `FAM_HR_OUT_FUNC) o_reg_rdata <= out_func;
               else if (i_reg_addr == `FAM_HR_COMM_TMO) o_reg_rdata <= comm_tmo;
               else if (i_reg_addr == `FAM_HR_INPUT_TYPE) o_reg_rdata <= input_type;
               else if (wr_fix[2]) o_reg_rdata <= fix_reg[wr_fix[1:0]];
               else o_reg_rdata <= `FAM_ZERO16;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Second tick and link watchdog
   // ----------------------------------------------------------------
   reg [31:0] tick_cnt;
   reg tick_s;
   reg [15:0] wd_cnt;
   reg comm_lost;

   // One-cycle enable per second feeds both the watchdog and restart delay
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         tick_cnt <= 32'h00000000;
         tick_s <= 1'b0;
      end else if (tick_cnt >= TICKS_PER_S - 32'h00000001) begin
         tick_cnt <= 32'h00000000;
         tick_s <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h00000001;
         tick_s <= 1'b0;
      end
   end

   // Any access by the master restarts the watchdog; zero timeout disables it
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         wd_cnt <= `FAM_ZERO16;
         comm_lost <= 1'b0;
      end else if (i_reg_wr || i_reg_rd || comm_tmo == `FAM_ZERO16) begin
         wd_cnt <= `FAM_ZERO16;
         comm_lost <= 1'b0;
      end else if (tick_s && !comm_lost) begin
         if (wd_cnt + 16'h0001 >= comm_tmo) comm_lost <= 1'b1;
         wd_cnt <= wd_cnt + 16'h0001;
      end
   end

   // ----------------------------------------------------------------
   // Alarm state machine
   // ----------------------------------------------------------------
   // Input voltage fault only counts while the motor is stopped
   wire vin_flt = pin_s[6] & ~motor_running_s;
   wire [12:0] faults = {temp_hot_s, pin_s[10], pin_s[9], pin_s[8], pin_s[7], vin_flt,
                         pin_s[5], comm_lost, pin_s[4], pin_s[3], pin_s[2], pin_s[1], pin_s[0]};
   wire [16:0] pick = fam_pick(faults);
   wire any_fault = |faults;
   wire is_sync = (pick[15:8] == `FAM_GRP_SYNC);
   wire analog_clear = (mode == `FAM_MODE_ANALOG) & ref_zero_s;
   wire clear_req = gen_reset | fix_clear | analog_clear;
   wire is_temp = (grp_code == `FAM_GRP_MISC) && (det_code == `FAM_DET_TEMP);
   reg [2:0] sync_fails;
   reg [15:0] wait_s;
   reg [1:0] strap_cnt;

   // Strap the power class once the synchroniser has filled; its reset zeros are no strap
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         pwr_class <= 2'h0;
         class_taken <= 1'b0;
         strap_cnt <= 2'h0;
      end else if (!class_taken) begin
         if (strap_cnt == `FAM_SYNC_DEPTH) begin
            pwr_class <= pin_s[15:14];
            class_taken <= 1'b1;
         end else begin
            strap_cnt <= strap_cnt + 2'h1;
         end
      end
   end

   // Codes latch on the first fault; a blocking fault in a restart wait replaces them; cleared when the alarm is left
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         state <= ST_RUN;
         grp_code <= `FAM_GRP_NONE;
         det_code <= `FAM_DET_NONE;
         sync_fails <= 3'h0;
         wait_s <= `FAM_ZERO16;
         o_motor_stop <= 1'b0;
         o_restart <= 1'b0;
         o_alarm_active <= 1'b0;
      end else begin
         o_restart <= 1'b0;
         case (state)
            ST_RUN: begin
               // A fault seen with a clear in flight still latches: set wins
               if (any_fault && class_taken) begin
                  grp_code <= pick[15:8];
                  det_code <= pick[7:0];
                  o_motor_stop <= 1'b1;
                  o_alarm_active <= 1'b1;
                  wait_s <= `FAM_ZERO16;
                  if (is_sync) sync_fails <= sync_fails + 3'h1;
                  if (pick[16]) begin
                     state <= ST_BLOCK;
                  end else if (is_sync && pwr_class == `FAM_PWR_TOP && sync_fails >= `FAM_SYNC_LAST) begin
                     state <= ST_BLOCK;
                  end else begin
                     state <= ST_AUTO;
                  end
               end
            end
            ST_AUTO: begin
               if (any_fault && pick[16]) begin
                  // A blocking fault overrides a pending restart
                  grp_code <= pick[15:8];
                  det_code <= pick[7:0];
                  state <= ST_BLOCK;
               end else if (clear_req) begin
                  state <= ST_RUN;
                  grp_code <= `FAM_GRP_NONE;
                  det_code <= `FAM_DET_NONE;
                  sync_fails <= 3'h0;
                  o_motor_stop <= 1'b0;
                  o_alarm_active <= 1'b0;
                  o_restart <= 1'b1;
               end else if (is_temp) begin
                  if (!temp_hot_s) begin
                     state <= ST_RUN;
                     grp_code <= `FAM_GRP_NONE;
                     det_code <= `FAM_DET_NONE;
                     o_motor_stop <= 1'b0;
                     o_alarm_active <= 1'b0;
                     o_restart <= 1'b1;
                  end
               end else if (tick_s) begin
                  if (wait_s + 16'h0001 >= RESTART_S) begin
                     state <= ST_RUN;
                     grp_code <= `FAM_GRP_NONE;
                     det_code <= `FAM_DET_NONE;
                     o_motor_stop <= 1'b0;
                     o_alarm_active <= 1'b0;
                     o_restart <= 1'b1;
                  end
                  wait_s <= wait_s + 16'h0001;
               end
            end
            ST_BLOCK: begin
               // Only a reset action leaves; a power cycle is the chip reset
               if (clear_req) begin
                  state <= ST_RUN;
                  grp_code <= `FAM_GRP_NONE;
                  det_code <= `FAM_DET_NONE;
                  sync_fails <= 3'h0;
                  o_motor_stop <= 1'b0;
                  o_alarm_active <= 1'b0;
                  o_restart <= 1'b1;
               end
            end
            default: begin
               state <= ST_RUN;
            end
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Digital output
   // ----------------------------------------------------------------
   // Other output functions belong to the speed logic; here they read low
   always @(posedge i_clk_sys or negedge i_rst_b) begin
      if (!i_rst_b) begin
         o_dout <= 1'b0;
      end else begin
         o_dout <= (out_func == `FAM_OUT_FUNC_ALARM) && (state != ST_RUN);
      end
   end

endmodule // fam_alarm_manager
`default_nettype wire

/* sim/fam_checker.sv */
// Port-level assertions for the fan alarm manager
`default_nettype none
module fam_checker #(
   parameter [15:0] FW_VERSION = 16'h0000,
   parameter [15:0] DRV_MODEL = 16'h0000
) (
   input wire logic i_clk_sys,
   input wire logic i_rst_b,
   input wire logic i_reg_rd,
   input wire logic i_reg_is_input,
   input wire logic [15:0] i_reg_addr,
   input wire logic i_flt_mem,
   input wire logic [15:0] o_reg_rdata,
   input wire logic o_reg_rack,
   input wire logic o_motor_stop,
   input wire logic o_restart,
   input wire logic o_alarm_active,
   input wire logic o_dout
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge i_clk_sys);
   endclocking
   default disable iff (!i_rst_b);
   // ----------------------------------------
   // Steps of reads, fault capture and restart
   // ----------------------------------------
   sequence s_ir_read(a);
      i_reg_rd && i_reg_is_input && i_reg_addr == a;
   endsequence
   // Three clean samples in run state leave room for the two-flop synchroniser
   sequence s_mem_run;
      (i_flt_mem && !o_alarm_active) [*3];
   endsequence
   sequence s_pulse_end;
      !o_alarm_active ##1 !o_restart;
   endsequence
   a_read_answer: assert property (i_reg_rd |=> o_reg_rack)
      else $error("read strobe got no answer");
   a_answer_cause: assert property (o_reg_rack |-> $past(i_reg_rd))
      else $error("answer without a read");
   a_fw_value: assert property (s_ir_read(16'h0000) |=> o_reg_rdata == FW_VERSION)
      else $error("firmware word wrong");
   a_model_value: assert property (s_ir_read(16'h0001) |=> o_reg_rdata == DRV_MODEL)
      else $error("driver model word wrong");
   a_idle_codes: assert property (i_reg_rd && i_reg_is_input && i_reg_addr == 16'h000A && !o_alarm_active
      |=> o_reg_rdata == 16'h0000) else $error("group code nonzero with no alarm");
   a_stop_alarm: assert property (o_alarm_active |-> o_motor_stop)
      else $error("motor not held during alarm");
   a_mem_latch: assert property (s_mem_run |-> ##[1:2] (o_alarm_active && o_motor_stop))
      else $error("memory fault not latched");
   a_leave_restart: assert property ($fell(o_alarm_active) |-> o_restart && !o_motor_stop)
      else $error("alarm left without restart");
   a_restart_once: assert property (o_restart |-> s_pulse_end)
      else $error("restart pulse malformed");
   a_dout_alarm: assert property (o_dout |-> o_alarm_active || $past(o_alarm_active))
      else $error("alarm output high with no alarm");
endmodule // fam_checker
`default_nettype wire

/* sim/fam_master.sv */
// Behavioural register bus master standing in for the serial link controller
`default_nettype none
module fam_master (
   input wire logic i_clk_sys,
   output var logic o_wr,
   output var logic o_rd,
   output var logic o_is_input,
   output var logic [15:0] o_addr,
   output var logic [15:0] o_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // Idle bus from time zero
   initial begin
      o_wr = 1'b0;
      o_rd = 1'b0;
      o_is_input = 1'b0;
      o_addr = 16'h0000;
      o_wdata = 16'h0000;
   end
   // One word per request; the decoder strobe lasts exactly one cycle
   task automatic xfer(input logic w, input logic inp, input logic [15:0] a, input logic [15:0] d);
      @(posedge i_clk_sys);
      #1;
      o_wr = w;
      o_rd = ~w;
      o_is_input = inp;
      o_addr = a;
      o_wdata = d;
      @(posedge i_clk_sys);
      #1;
      o_wr = 1'b0;
      o_rd = 1'b0;
      // Released lines carry the inverse so a stale word is never taken as valid
      o_addr = ~a;
      o_wdata = ~d;
   endtask
endmodule // fam_master
`default_nettype wire

/* sim/test_fan_alarm_manager.sv */
// Self-checking bench for the fan alarm manager
`default_nettype none
module test_fan_alarm_manager;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int LIMIT = 20000;
   localparam logic [15:0] FW = 16'h0203; // Arbitrary value
   localparam logic [15:0] DRV = 16'h5A5A; // Arbitrary value
   localparam logic [11:0] BLK = 12'h383;
   localparam logic [7:0] DET [12] = '{8'h00, 8'h00, 8'h00, 8'h01, 8'h20, 8'h21, 8'h22, 8'h31, 8'h32,
      8'h33, 8'h34, 8'h71};
   localparam logic [15:0] TYPES [3][4] = '{'{16'h0001, 16'h0004, 16'h0007, 16'h000A},
      '{16'h0002, 16'h0006, 16'h0009, 16'h000C}, '{16'h0000, 16'h0005, 16'h0008, 16'h000B}};
   logic i_clk_sys = 1'b0;
   logic i_rst_b = 1'b0;
   logic [11:0] flt = 12'h000;
   logic ref_zero = 1'b0;
   logic run = 1'b0;
   logic [1:0] pclass = 2'h0;
   logic [15:0] rnd;
   wire logic wr, rd, is_in, rack, stop, restart, alarm, dout;
   wire logic [15:0] addr, wdata, rdata;
   logic [15:0] expq [$];
   int miscompares = 0;
   int total_checks = 0;
   int cycles = 0;
   always #12.5 i_clk_sys = ~i_clk_sys;
   fam_master mst(.i_clk_sys(i_clk_sys), .o_wr(wr), .o_rd(rd), .o_is_input(is_in), .o_addr(addr), .o_wdata(wdata));
   // Short second so restart waits stay within twenty cycles
   fam_alarm_manager #(.FW_VERSION(FW), .DRV_MODEL(DRV), .TICKS_PER_S(32'h0000000A), .RESTART_S(16'h0002)) dut(
      .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_reg_wr(wr), .i_reg_rd(rd), .i_reg_is_input(is_in),
      .i_reg_addr(addr), .i_reg_wdata(wdata), .i_flt_mem(flt[0]), .i_flt_short(flt[1]), .i_flt_sync(flt[2]),
      .i_flt_vin(flt[3]), .i_flt_ovp(flt[4]), .i_flt_uvp(flt[5]), .i_flt_relay(flt[6]), .i_flt_phase(flt[9:7]),
      .i_flt_istart(flt[10]), .i_temp_hot(flt[11]), .i_motor_running(run), .i_ref_zero(ref_zero),
      .i_power_class(pclass), .o_reg_rdata(rdata), .o_reg_rack(rack), .o_motor_stop(stop),
      .o_restart(restart), .o_alarm_active(alarm), .o_dout(dout));
   // ----------------------------------------
   // Shared tasks
   // ----------------------------------------
   task automatic tick(input int n);
      repeat (n) @(posedge i_clk_sys);
      #1;
   endtask
   task automatic chk_word(input logic [15:0] got, input logic [15:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t read %h expected %h", $time, got, exp);
      end
   endtask
   task automatic chk_out(input logic [2:0] got, input logic [2:0] exp);
      total_checks++;
      if (got !== exp) begin
         miscompares++;
         $display("[ERR] %0t outputs %b expected %b", $time, got, exp);
      end
   endtask
   task automatic rd_exp(input logic inp, input logic [15:0] a, input logic [15:0] exp);
      expq.push_back(exp);
      mst.xfer(1'b0, inp, a, 16'h0000);
   endtask
   task automatic wr_reg(input logic [15:0] a, input logic [15:0] d);
      mst.xfer(1'b1, 1'b0, a, d);
   endtask
   // Bounded wait; the restart pulse stands one cycle only
   task automatic wait_restart();
      int n;
      for (n = 0; n < 40 && restart !== 1'b1; n++) @(negedge i_clk_sys);
      chk_out({restart, alarm, stop}, 3'b100);
      tick(2);
   endtask
   // Codes are read after the pin drops, except heat which would clear itself
   task automatic one_fault(input int k, input logic blk);
      flt[k] = 1'b1;
      tick(5);
      flt[k] = (k == 11);
      tick(3);
      chk_out({stop, alarm, dout}, 3'b111);
      rd_exp(1'b1, 16'h000A, (k < 3) ? 16'(k) + 16'h0001 : 16'h0004);
      rd_exp(1'b1, 16'h0011, {8'h00, DET[k]});
      flt[k] = 1'b0;
      if (blk) begin
         tick(25);
         chk_out({stop, alarm, dout}, 3'b111);
         wr_reg(16'h0000, 16'h0001);
      end
      wait_restart();
      rd_exp(1'b1, 16'h000A, 16'h0000);
   endtask
   task automatic end_test(input string s);
      $display("test %s done", s);
   endtask
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, miscompares);
      if (miscompares == 0 && total_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Oldest note against each read answer
   always @(negedge i_clk_sys) begin
      if (rack === 1'b1) begin
         chk_word(rdata, expq.pop_front());
      end
   end
   // Hang guard
   always @(posedge i_clk_sys) begin
      cycles++;
      if (cycles == LIMIT) begin
         miscompares++;
         finish_test();
      end
   end
   // ----------------------------------------
   // Stimulus
   // ----------------------------------------
   initial begin
      void'($urandom(32'hA88ACC00));
      pclass = 2'($urandom_range(2, 0));
      tick(20);
      i_rst_b = 1'b1;
      tick(3);
      rd_exp(1'b1, 16'h0000, FW);
      rd_exp(1'b1, 16'h0001, DRV);
      mst.xfer(1'b1, 1'b1, 16'h0000, 16'h1234);
      rd_exp(1'b1, 16'h0000, FW);
      rd_exp(1'b0, 16'h002C, 16'h0001);
      rnd = 16'($urandom());
      wr_reg(16'h002C, rnd);
      rd_exp(1'b0, 16'h002C, rnd);
      rd_exp(1'b0, 16'h0099, 16'h0000);
      rd_exp(1'b0, 16'h0000, 16'h0000);
      wr_reg(16'h002E, 16'h0001);
      rd_exp(1'b0, 16'h002E, 16'h0001);
      chk_out({stop, alarm, dout}, 3'b000);
      end_test("registers");
      for (int k = 0; k < 12; k++) one_fault(k, BLK[k]);
      end_test("alarm table");
      // Supply fault is ignored while the motor turns
      run = 1'b1;
      flt[3] = 1'b1;
      tick(8);
      chk_out({stop, alarm, dout}, 3'b000);
      flt[3] = 1'b0;
      run = 1'b0;
      tick(3);
      // Reset in mid-run with the top power class strapped
      i_rst_b = 1'b0;
      pclass = 2'h3;
      tick(5);
      i_rst_b = 1'b1;
      tick(3);
      wr_reg(16'h002E, 16'h0001);
      for (int i = 0; i < 5; i++) one_fault(2, i == 4);
      end_test("sync limit");
      wr_reg(16'h0015, 16'h0000);
      wr_reg(16'h001E, 16'h0000);
      wr_reg(16'h0027, 16'h0000);
      for (int m = 0; m < 4; m++) begin
         for (int c = 0; c < 3; c++) begin
            wr_reg(16'h0040, TYPES[c][m]);
            flt[0] = 1'b1;
            tick(5);
            flt[0] = 1'b0;
            chk_out({stop, alarm, dout}, 3'b111);
            case (c)
               0: ref_zero = 1'b1;
               1: wr_reg(16'h0032, 16'h0000);
               default: begin
                  wr_reg(16'h0042, 16'h0000);
                  tick(3);
                  chk_out({stop, alarm, dout}, 3'b111);
                  wr_reg(16'h0000, 16'h0001);
               end
            endcase
            wait_restart();
            ref_zero = 1'b0;
         end
      end
      end_test("clear modes");
      wr_reg(16'h0038, 16'h0003);
      tick(40);
      chk_out({stop, alarm, dout}, 3'b111);
      rd_exp(1'b1, 16'h0011, 16'h00FF);
      wr_reg(16'h0038, 16'h0000);
      wr_reg(16'h0000, 16'h0001);
      wait_restart();
      end_test("link watchdog");
      finish_test();
   end
endmodule // test_fan_alarm_manager
bind fam_alarm_manager fam_checker #(.FW_VERSION(FW_VERSION), .DRV_MODEL(DRV_MODEL)) u_chk(
   .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_reg_rd(i_reg_rd), .i_reg_is_input(i_reg_is_input),
   .i_reg_addr(i_reg_addr), .i_flt_mem(i_flt_mem), .o_reg_rdata(o_reg_rdata), .o_reg_rack(o_reg_rack),
   .o_motor_stop(o_motor_stop), .o_restart(o_restart), .o_alarm_active(o_alarm_active), .o_dout(o_dout));
`default_nettype wire
